// ### include/stage_cfg.svh
// constants for the stage switch selector block
// assumes inclusion by the package and by the top module
`ifndef STAGE_CFG_SVH
`define STAGE_CFG_SVH

`define SEL_ADDR_W 8
`define SEL_DRIVER_COUNT 112
`define SEL_CODE_MIN 8'h01
`define SEL_CODE_MAX 8'h70
`define SEL_TEST_ZEROS 8'h00
`define SEL_TEST_ONES 8'hFF
`define SEL_IDX_W 7

`define REG_ADDR_W 4
`define REG_DATA_W 32
`define REG_DISC 4'h0
`define REG_STATUS 4'h1
`define REG_MASK 4'h2
`define REG_LOWER 4'h3
`define REG_UPPER 4'h4
`define REG_LOWER_CNT 4'h5
`define REG_UPPER_CNT 4'h6
`define REG_LINES 4'h7

`define DISC_RESET 8'h00
`define MASK_RESET 8'h00
`define CNT_RESET 16'h0000
`define DISC_INNER 0
`define DISC_OUTER 1
`define DISC_ALL_OUTER 2
`define DISC_FLUID 3
`define DISC_SEPARATED 4
`define DISC_LOX_STOP 5
`define DISC_LH2_START 6
`define DISC_LH2_STOP 7

`define EVT_W 8
`define EVT_FIRE_LO 0
`define EVT_FIRE_UP 1
`define EVT_RESET_LO 2
`define EVT_RESET_UP 3
`define EVT_BAD_LO 4
`define EVT_BAD_UP 5
`define EVT_TEST_LO 6
`define EVT_TEST_UP 7

`endif

// ### include/stage_pkg.sv
// types shared by the stage switch selector modules
// assumes stage_cfg.svh is on the include path
package stage_pkg;
`include "stage_cfg.svh"

typedef enum logic [1:0] {
    SEL_IDLE = 2'b00,
    SEL_LOADED = 2'b01,
    SEL_FIRING = 2'b10
} sel_phase_e;

typedef struct packed {
    sel_phase_e phase;
    logic [`SEL_ADDR_W-1:0] held;
    logic [`SEL_DRIVER_COUNT-1:0] driver;
    logic fire;
    logic rst;
    logic bad;
    logic test;
} sel_state_s;

typedef struct packed {
    logic [`EVT_W-1:0] status;
    logic irq;
} evt_state_s;

typedef struct packed {
    logic [7:0] disc;
    logic [`EVT_W-1:0] mask;
    logic [`SEL_ADDR_W-1:0] verify;
    logic [15:0] cnt_lo;
    logic [15:0] cnt_up;
    logic [`SEL_ADDR_W-1:0] last_lo;
    logic [`SEL_ADDR_W-1:0] last_up;
    logic [`REG_DATA_W-1:0] rd_data;
} top_state_s;

endpackage

// ### core/selector_unit.sv
// one stage switch selector: address latch, decode, driver bank
// assumes synchronous inputs and an already synchronised reset
`timescale 1ns/1ps
`include "stage_cfg.svh"
module selector_unit import stage_pkg::*; (
    input wire logic clock,
    input wire logic resetn,
    input wire logic pick,
    input wire logic read,
    input wire logic reset_cmd,
    input wire logic [`SEL_ADDR_W-1:0] address,
    output logic [`SEL_ADDR_W-1:0] held_addr,
    output logic [1:0] phase,
    output logic [`SEL_DRIVER_COUNT-1:0] driver,
    output logic fire_evt,
    output logic reset_evt,
    output logic bad_evt,
    output logic test_evt
);
    sel_state_s s_r;
    sel_state_s s_nxt;
    logic [`SEL_ADDR_W-1:0] inv;
    logic [`SEL_ADDR_W-1:0] code;
    logic in_true;
    logic in_comp;

    always_comb begin
        inv = ~s_r.held;
        in_true = (s_r.held >= `SEL_CODE_MIN) && (s_r.held <= `SEL_CODE_MAX);
        in_comp = (inv >= `SEL_CODE_MIN) && (inv <= `SEL_CODE_MAX);
        code = in_true ? s_r.held : inv;
        s_nxt = s_r;
        s_nxt.fire = 1'b0;
        s_nxt.rst = 1'b0;
        s_nxt.bad = 1'b0;
        s_nxt.test = 1'b0;
        unique case (s_r.phase)
            SEL_IDLE: begin
                if (pick && !read) begin
                    s_nxt.held = address;
                    s_nxt.phase = SEL_LOADED;
                end
            end
            SEL_LOADED: begin
                if (pick && read) begin
                    s_nxt.phase = SEL_FIRING;
                    if (s_r.held == `SEL_TEST_ZEROS ||
                        s_r.held == `SEL_TEST_ONES) begin
                        s_nxt.test = 1'b1;
                    end else if (in_true || in_comp) begin
                        s_nxt.driver = '0;
                        s_nxt.driver[code[`SEL_IDX_W-1:0] - 7'h01] = 1'b1;
                        s_nxt.fire = 1'b1;
                    end else begin
                        s_nxt.bad = 1'b1;
                    end
                end else if (pick) begin
                    s_nxt.held = address;
                end
            end
            SEL_FIRING: begin
                if (!read) begin
                    s_nxt.held = '0;
                    s_nxt.driver = '0;
                    s_nxt.phase = SEL_IDLE;
                end
            end
            default: begin
                s_nxt.phase = SEL_IDLE;
            end
        endcase
        if (pick && reset_cmd) begin
            s_nxt.held = '0;
            s_nxt.driver = '0;
            s_nxt.phase = SEL_IDLE;
            s_nxt.fire = 1'b0;
            s_nxt.bad = 1'b0;
            s_nxt.test = 1'b0;
            s_nxt.rst = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign held_addr = s_r.held;
    assign phase = s_r.phase;
    assign driver = s_r.driver;
    assign fire_evt = s_r.fire;
    assign reset_evt = s_r.rst;
    assign bad_evt = s_r.bad;
    assign test_evt = s_r.test;
endmodule

// ### core/event_latch.sv
// sticky event status with mask and one level interrupt
// assumes clear comes from a status read; a new event wins over it
`timescale 1ns/1ps
`include "stage_cfg.svh"
module event_latch import stage_pkg::*; (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [`EVT_W-1:0] events,
    input wire logic [`EVT_W-1:0] mask,
    input wire logic clear,
    output logic [`EVT_W-1:0] status,
    output logic irq
);
    evt_state_s s_r;
    evt_state_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.status = (clear ? '0 : s_r.status) | events;
        s_nxt.irq = |(s_nxt.status & mask);
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign status = s_r.status;
    assign irq = s_r.irq;
endmodule

// ### core/stage_switch_selector.sv
// stage side of the flight data adapter link: two switch selectors,
// address verify return, stage status discretes and a register port
// assumes all inputs synchronous to clock; resetn is asynchronous
//
// Function
// - an 8-bit code, true or complemented, selects one of 112 drivers.
// - all-zeros and all-ones codes are test patterns and drive nothing.
// - the verify lines return the complement of the held address.
// - the verify lines are active only while verify enable is high.
// - the address is loaded first and read then fires the chosen driver.
// - dropping read clears the held address and turns the driver off.
// - an explicit reset with the stage picked clears the held address and the driver.
// - the lower selector loads, fires and resets only while its stage pick is high.
// - the upper selector loads, fires and resets only while its own stage pick is high.
// - the stage drives inner, any outer and all outer engine lost lines.
// - the stage drives a separation discrete to the adapter.
`timescale 1ns/1ps
`include "stage_cfg.svh"
module stage_switch_selector import stage_pkg::*; (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [`REG_ADDR_W-1:0] reg_addr,
    input wire logic [`REG_DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [`REG_DATA_W-1:0] reg_rdata,
    input wire logic [`SEL_ADDR_W-1:0] sel_address,
    input wire logic stage_selector_pick_lower,
    input wire logic stage_selector_pick_upper,
    input wire logic read_lower,
    input wire logic read_upper,
    input wire logic reset_lower,
    input wire logic reset_upper,
    input wire logic verify_enable,
    output logic [`SEL_ADDR_W-1:0] verify_return,
    output logic [`SEL_DRIVER_COUNT-1:0] driver_lower,
    output logic [`SEL_DRIVER_COUNT-1:0] driver_upper,
    output logic inner_engine_lost,
    output logic outer_engine_lost,
    output logic all_outer_engines_lost,
    output logic fluid_level_reached,
    output logic stage_separated,
    output logic lox_vent_stop_req,
    output logic lh2_vent_start_req,
    output logic lh2_vent_stop_req,
    output logic irq
);
    logic rst_meta_r;
    logic rst_sync_r;
    top_state_s s_r;
    top_state_s s_nxt;

    logic [`SEL_ADDR_W-1:0] held_lo;
    logic [`SEL_ADDR_W-1:0] held_up;
    logic [1:0] phase_lo;
    logic [1:0] phase_up;
    logic fire_lo;
    logic fire_up;
    logic rst_lo;
    logic rst_up;
    logic bad_lo;
    logic bad_up;
    logic test_lo;
    logic test_up;
    logic [`EVT_W-1:0] events;
    logic [`EVT_W-1:0] status;
    logic status_clear;
    logic irq_line;

    // reset release through two flops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta_r <= 1'b0;
            rst_sync_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_sync_r <= rst_meta_r;
        end
    end

    selector_unit lower_unit (
        .clock(clock),
        .resetn(rst_sync_r),
        .pick(stage_selector_pick_lower),
        .read(read_lower),
        .reset_cmd(reset_lower),
        .address(sel_address),
        .held_addr(held_lo),
        .phase(phase_lo),
        .driver(driver_lower),
        .fire_evt(fire_lo),
        .reset_evt(rst_lo),
        .bad_evt(bad_lo),
        .test_evt(test_lo)
    );

    selector_unit upper_unit (
        .clock(clock),
        .resetn(rst_sync_r),
        .pick(stage_selector_pick_upper),
        .read(read_upper),
        .reset_cmd(reset_upper),
        .address(sel_address),
        .held_addr(held_up),
        .phase(phase_up),
        .driver(driver_upper),
        .fire_evt(fire_up),
        .reset_evt(rst_up),
        .bad_evt(bad_up),
        .test_evt(test_up)
    );

    always_comb begin
        events = '0;
        events[`EVT_FIRE_LO] = fire_lo;
        events[`EVT_FIRE_UP] = fire_up;
        events[`EVT_RESET_LO] = rst_lo;
        events[`EVT_RESET_UP] = rst_up;
        events[`EVT_BAD_LO] = bad_lo;
        events[`EVT_BAD_UP] = bad_up;
        events[`EVT_TEST_LO] = test_lo;
        events[`EVT_TEST_UP] = test_up;
    end

    assign status_clear = reg_read && (reg_addr == `REG_STATUS);

    event_latch events_unit (
        .clock(clock),
        .resetn(rst_sync_r),
        .events(events),
        .mask(s_r.mask),
        .clear(status_clear),
        .status(status),
        .irq(irq_line)
    );

    always_comb begin
        s_nxt = s_r;

        // software writes
        if (reg_write) begin
            unique case (reg_addr)
                `REG_DISC: begin
                    s_nxt.disc = reg_wdata[7:0];
                end
                `REG_MASK: begin
                    s_nxt.mask = reg_wdata[`EVT_W-1:0];
                end
                `REG_LOWER_CNT: begin
                    s_nxt.cnt_lo = `CNT_RESET;
                end
                `REG_UPPER_CNT: begin
                    s_nxt.cnt_up = `CNT_RESET;
                end
                default: begin
                    s_nxt.disc = s_r.disc;
                end
            endcase
        end

        // executed command tally, wraps
        if (fire_lo) begin
            s_nxt.cnt_lo = s_r.cnt_lo + 16'h0001;
            s_nxt.last_lo = held_lo;
        end
        if (fire_up) begin
            s_nxt.cnt_up = s_r.cnt_up + 16'h0001;
            s_nxt.last_up = held_up;
        end

        // shared verify lines follow the picked selector
        s_nxt.verify = '0;
        if (verify_enable) begin
            if (stage_selector_pick_lower) begin
                s_nxt.verify = ~held_lo;
            end else if (stage_selector_pick_upper) begin
                s_nxt.verify = ~held_up;
            end
        end

        // read data for one cycle only
        s_nxt.rd_data = '0;
        if (reg_read) begin
            unique case (reg_addr)
                `REG_DISC: begin
                    s_nxt.rd_data[7:0] = s_r.disc;
                end
                `REG_STATUS: begin
                    s_nxt.rd_data[`EVT_W-1:0] = status;
                end
                `REG_MASK: begin
                    s_nxt.rd_data[`EVT_W-1:0] = s_r.mask;
                end
                `REG_LOWER: begin
                    s_nxt.rd_data[7:0] = held_lo;
                    s_nxt.rd_data[9:8] = phase_lo;
                    s_nxt.rd_data[23:16] = s_r.last_lo;
                end
                `REG_UPPER: begin
                    s_nxt.rd_data[7:0] = held_up;
                    s_nxt.rd_data[9:8] = phase_up;
                    s_nxt.rd_data[23:16] = s_r.last_up;
                end
                `REG_LOWER_CNT: begin
                    s_nxt.rd_data[15:0] = s_r.cnt_lo;
                end
                `REG_UPPER_CNT: begin
                    s_nxt.rd_data[15:0] = s_r.cnt_up;
                end
                `REG_LINES: begin
                    s_nxt.rd_data[0] = stage_selector_pick_lower;
                    s_nxt.rd_data[1] = stage_selector_pick_upper;
                    s_nxt.rd_data[2] = read_lower;
                    s_nxt.rd_data[3] = read_upper;
                    s_nxt.rd_data[4] = reset_lower;
                    s_nxt.rd_data[5] = reset_upper;
                    s_nxt.rd_data[6] = verify_enable;
                    s_nxt.rd_data[15:8] = sel_address;
                end
                default: begin
                    s_nxt.rd_data = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rst_sync_r) begin
        if (!rst_sync_r) begin
            s_r.disc <= `DISC_RESET;
            s_r.mask <= `MASK_RESET;
            s_r.verify <= '0;
            s_r.cnt_lo <= `CNT_RESET;
            s_r.cnt_up <= `CNT_RESET;
            s_r.last_lo <= '0;
            s_r.last_up <= '0;
            s_r.rd_data <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rd_data;
    assign verify_return = s_r.verify;
    assign irq = irq_line;

    // stage status discretes straight from the control register
    assign inner_engine_lost = s_r.disc[`DISC_INNER];
    assign outer_engine_lost = s_r.disc[`DISC_OUTER];
    assign all_outer_engines_lost = s_r.disc[`DISC_ALL_OUTER];
    assign fluid_level_reached = s_r.disc[`DISC_FLUID];
    assign stage_separated = s_r.disc[`DISC_SEPARATED];
    assign lox_vent_stop_req = s_r.disc[`DISC_LOX_STOP];
    assign lh2_vent_start_req = s_r.disc[`DISC_LH2_START];
    assign lh2_vent_stop_req = s_r.disc[`DISC_LH2_STOP];
endmodule

// ### tb/stage_sel_props.sv
// assertions on the stage switch selector top ports
// assumes a bind onto stage_switch_selector, one clock domain
`timescale 1ns/1ps
`include "stage_cfg.svh"
module stage_sel_props (
    input logic clock,
    input logic resetn,
    input logic reg_read,
    input logic reg_write,
    input logic [`REG_ADDR_W-1:0] reg_addr,
    input logic [`REG_DATA_W-1:0] reg_wdata,
    input logic [`REG_DATA_W-1:0] reg_rdata,
    input logic [`SEL_ADDR_W-1:0] sel_address,
    input logic stage_selector_pick_lower,
    input logic stage_selector_pick_upper,
    input logic read_lower,
    input logic reset_lower,
    input logic verify_enable,
    input logic [`SEL_ADDR_W-1:0] verify_return,
    input logic [`SEL_DRIVER_COUNT-1:0] driver_lower,
    input logic [`SEL_DRIVER_COUNT-1:0] driver_upper,
    input logic inner_engine_lost,
    input logic outer_engine_lost,
    input logic all_outer_engines_lost,
    input logic fluid_level_reached,
    input logic stage_separated
);
    default clocking @(posedge clock);
    endclocking
    default disable iff (!resetn);
    wire [4:0] disc = {stage_separated, fluid_level_reached,
        all_outer_engines_lost, outer_engine_lost, inner_engine_lost};
    wire lo_load = stage_selector_pick_lower && !read_lower &&
        !reset_lower && verify_enable;
    a_verify_off: assert property (
        !verify_enable |=> verify_return == 8'h00)
        else $error("verify lines active while disabled");
    a_verify_value: assert property (
        !read_lower ##1 (lo_load && $stable(sel_address))[*2]
        |=> verify_return == ~$past(sel_address))
        else $error("verify lines not the address complement");
    a_one_driver: assert property (
        $onehot0(driver_lower) && $onehot0(driver_upper))
        else $error("more than one driver on");
    a_drop_clears: assert property (
        !read_lower |=> driver_lower == '0)
        else $error("driver on without read");
    a_pick_lower: assert property (
        $rose(|driver_lower) |-> $past(stage_selector_pick_lower))
        else $error("lower driver fired without pick");
    a_pick_upper: assert property (
        $rose(|driver_upper) |-> $past(stage_selector_pick_upper))
        else $error("upper driver fired without pick");
    a_reset_clears: assert property (
        reset_lower && stage_selector_pick_lower |=> driver_lower == '0)
        else $error("driver on after explicit reset");
    a_rdata_idle: assert property (
        !reg_read |=> reg_rdata == '0)
        else $error("read data without read strobe");
    a_disc_write: assert property (
        reg_write && reg_addr == `REG_DISC |=> disc == $past(reg_wdata[4:0]))
        else $error("stage discretes differ from written value");
    c_fire_lo: cover property ($rose(|driver_lower));
    c_fire_up: cover property ($rose(|driver_upper));
    c_abort: cover property (reset_lower && stage_selector_pick_lower);
endmodule

// ### tb/adapter_model.sv
// flight data adapter model driving both switch selectors
// assumes its tasks are called from the bench between clock edges
`timescale 1ns/1ps
module adapter_model #(
    // cycles standing in for the seconds of the vent delay
    parameter int VENT_DELAY = 15
) (
    input logic clock,
    input logic [7:0] verify_return,
    input logic [3:0] stage_req,
    output logic [7:0] address,
    output logic [1:0] pick,
    output logic [1:0] read,
    output logic [1:0] abort,
    output logic verify_on
);
    bit mismatch = 1'b0;
    // computer side reactions to the stage requests
    logic [3:0] req_q = 4'h0;
    int vent_wait = 0;
    bit fluid_irq = 1'b0;
    bit ullage_fired = 1'b0;
    bit vent_cmd = 1'b0;
    bit lox_vent = 1'b1;
    wire [3:0] req_rise = stage_req & ~req_q;
    always @(posedge clock) begin
        req_q <= stage_req;
        if (req_rise[0]) begin
            fluid_irq <= 1'b1;
        end
        if (req_rise[1]) begin
            lox_vent <= 1'b0;
        end
        if (req_rise[3]) begin
            vent_wait <= 0;
            vent_cmd <= 1'b0;
        end else if (req_rise[2]) begin
            ullage_fired <= 1'b1;
            vent_wait <= VENT_DELAY;
        end else if (vent_wait == 1) begin
            vent_cmd <= 1'b1;
            vent_wait <= 0;
        end else if (vent_wait > 1) begin
            vent_wait <= vent_wait - 1;
        end
    end
    initial begin
        address = 8'h00;
        pick = 2'b00;
        read = 2'b00;
        abort = 2'b00;
        verify_on = 1'b1;
    end
    task automatic abort_pulse(input int s);
        @(posedge clock);
        abort[s] <= 1'b1;
        @(posedge clock);
        abort[s] <= 1'b0;
        #1;
    endtask
    task automatic load(input int s, input logic [7:0] code, output bit ok);
        @(posedge clock);
        pick[s] <= 1'b1;
        address <= code;
        repeat (2) @(posedge clock);
        #1 ok = verify_return === ~code;
        if (!ok) begin
            mismatch = 1'b1;
            abort_pulse(s);
        end
    endtask
    task automatic fire(input int s);
        @(posedge clock);
        read[s] <= 1'b1;
        @(posedge clock);
        #1;
    endtask
    // on release read and pick drop and the address lines flip to their complement
    task automatic drop(input int s);
        @(posedge clock);
        read[s] <= 1'b0;
        pick[s] <= 1'b0;
        address <= ~address;
        @(posedge clock);
        #1;
    endtask
endmodule

// ### tb/testbench.sv
// self-checking bench for the stage switch selector
// assumes the adapter model drives the selector link side
`timescale 1ns/1ps
`include "stage_cfg.svh"
module testbench;
    localparam int ND = `SEL_DRIVER_COUNT;
    logic clock;
    logic resetn;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_write;
    logic reg_read;
    wire [31:0] reg_rdata;
    wire [7:0] adr, vret, disc;
    wire [1:0] pk, rdc, rsc;
    wire ven, irq;
    wire [ND-1:0] drv_lo, drv_up;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    logic [7:0] mask_m = 8'h00;
    int n_fire[2] = '{0, 0};
    logic [7:0] last_m[2] = '{8'h00, 8'h00};
    logic [7:0] codes[$] = '{8'h01, 8'h70, 8'h8F, 8'hFE, 8'hFA,
        8'h00, 8'hFF, 8'h71, 8'h8E};
    stage_switch_selector dut (
        .clock, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read,
        .reg_rdata, .sel_address(adr), .irq,
        .stage_selector_pick_lower(pk[0]), .stage_selector_pick_upper(pk[1]),
        .read_lower(rdc[0]), .read_upper(rdc[1]),
        .reset_lower(rsc[0]), .reset_upper(rsc[1]),
        .verify_enable(ven), .verify_return(vret),
        .driver_lower(drv_lo), .driver_upper(drv_up),
        .inner_engine_lost(disc[0]), .outer_engine_lost(disc[1]),
        .all_outer_engines_lost(disc[2]), .fluid_level_reached(disc[3]),
        .stage_separated(disc[4]), .lox_vent_stop_req(disc[5]),
        .lh2_vent_start_req(disc[6]), .lh2_vent_stop_req(disc[7]));
    adapter_model adapter (.clock, .verify_return(vret),
        .stage_req({disc[7:5], disc[3]}), .address(adr),
        .pick(pk), .read(rdc), .abort(rsc), .verify_on(ven));
    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            wrap_up();
        end
    end
    task automatic check(input logic [127:0] got, exp, input string m);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 check(reg_rdata, e, "register read");
    endtask
    // true or complemented code to one-hot driver, test codes none
    function automatic logic [ND-1:0] expd(input int c);
        int i;
        expd = '0;
        i = c > 127 ? 255 - c : c;
        if (i >= 1 && i <= ND) expd[i-1] = 1'b1;
    endfunction
    task automatic run(input int s, input logic [7:0] code);
        bit ok;
        int b;
        b = expd(code) != 0 ? 0 : (code == 8'h00 || code == 8'hFF) ? 6 : 4;
        if (b == 0) begin
            n_fire[s]++;
            last_m[s] = code;
        end
        adapter.load(s, code, ok);
        check(ok, 1'b1, "verify return");
        adapter.fire(s);
        check(s ? drv_up : drv_lo, expd(code), "driver");
        check(s ? drv_lo : drv_up, '0, "other stage");
        adapter.drop(s);
        check(drv_lo | drv_up, '0, "read drop");
        check(irq, mask_m[b+s], "irq level");
        rd(`REG_STATUS, 32'h1 << (b + s));
        @(posedge clock);
        #1 check(irq, 1'b0, "irq clear");
    endtask
    initial begin
        logic [7:0] c;
        bit ok;
        resetn = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        void'($urandom(32'h3951));
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        repeat (3) @(posedge clock);
        rd(`REG_STATUS, 32'h0);
        rd(`REG_MASK, 32'h0);
        rd(`REG_DISC, 32'h0);
        rd(4'hC, 32'h0);
        $display("test reset values done");
        wr(`REG_DISC, 32'h40);
        repeat (adapter.VENT_DELAY) @(posedge clock);
        #1 check(adapter.vent_cmd, 1'b0, "vent too early");
        repeat (2) @(posedge clock);
        #1 check(adapter.vent_cmd, 1'b1, "vent command");
        check(adapter.ullage_fired, 1'b1, "ullage firing");
        wr(`REG_DISC, 32'h0);
        wr(`REG_DISC, 32'h40);
        wr(`REG_DISC, 32'h80);
        repeat (adapter.VENT_DELAY + 2) @(posedge clock);
        #1 check(adapter.vent_cmd, 1'b0, "vent cycle stop");
        wr(`REG_DISC, 32'h28);
        repeat (2) @(posedge clock);
        #1 check(adapter.lox_vent, 1'b0, "oxygen vent stop");
        check(adapter.fluid_irq, 1'b1, "fluid level interrupt");
        $display("test stage requests done");
        c = 8'($urandom);
        wr(`REG_DISC, {24'h0, c});
        rd(`REG_DISC, {24'h0, c});
        check(disc, c, "discretes");
        $display("test discretes done");
        mask_m = 8'($urandom) | 8'h03;
        wr(`REG_MASK, {24'h0, mask_m});
        foreach (codes[i]) run(i % 2, codes[i]);
        repeat (6) begin
            c = 8'($urandom_range(1, 112));
            if ($urandom_range(0, 1)) c = ~c;
            run(int'($urandom_range(0, 1)), c);
        end
        $display("test codes done");
        rd(`REG_LOWER, {8'h0, last_m[0], 16'h0});
        rd(`REG_UPPER_CNT, n_fire[1]);
        rd(`REG_LOWER_CNT, n_fire[0]);
        c = 8'($urandom);
        wr(`REG_LOWER_CNT, {24'h0, c});
        rd(`REG_LOWER_CNT, 32'h0);
        adapter.load(0, 8'h22, ok);
        adapter.fire(0);
        adapter.abort_pulse(0);
        check(drv_lo, '0, "explicit reset");
        adapter.drop(0);
        rd(`REG_STATUS, 32'h05);
        $display("test explicit reset done");
        @(posedge clock);
        adapter.verify_on <= 1'b0;
        adapter.load(1, 8'h33, ok);
        check(vret, 8'h00, "verify off");
        check(adapter.mismatch, 1'b1, "mismatch seen");
        adapter.drop(1);
        rd(`REG_STATUS, 32'h08);
        @(posedge clock);
        adapter.verify_on <= 1'b1;
        $display("test verify disable done");
        adapter.load(1, 8'h10, ok);
        @(posedge clock);
        adapter.pick <= 2'b00;
        @(posedge clock);
        adapter.read <= 2'b11;
        repeat (2) @(posedge clock);
        #1 check(drv_lo | drv_up, '0, "no pick");
        rd(`REG_LINES, {16'h0, adr, 8'h4C});
        rd(`REG_UPPER, {8'h0, last_m[1], 8'h01, 8'h10});
        adapter.drop(0);
        adapter.drop(1);
        rd(`REG_STATUS, 32'h0);
        $display("test no pick done");
        wrap_up();
    end
endmodule
bind stage_switch_selector stage_sel_props chk (
    .clock, .resetn, .reg_read, .reg_write, .reg_addr, .reg_wdata,
    .reg_rdata, .sel_address, .stage_selector_pick_lower,
    .stage_selector_pick_upper, .read_lower, .reset_lower,
    .verify_enable, .verify_return, .driver_lower, .driver_upper,
    .inner_engine_lost, .outer_engine_lost, .all_outer_engines_lost,
    .fluid_level_reached, .stage_separated);
